// [hdl/oscrst_pkg.sv]
package oscrst_pkg;
  // Register byte offsets
  localparam logic [11:0] OSCRST_STAT_OFF = 12'h008;
  localparam logic [11:0] OSCRST_PRST_OFF = 12'h00c;
  localparam logic [11:0] OSCRST_MASK_OFF = 12'h020;
  localparam logic [11:0] OSCRST_IEN_OFF = 12'h024;
  localparam logic [11:0] OSCRST_LIVE_OFF = 12'h028;
  // Flag and clear bit positions
  localparam int OSCRST_RC40_BIT = 0;
  localparam int OSCRST_SLOWX_BIT = 1;
  localparam int OSCRST_RC8_BIT = 2;
  localparam int OSCRST_FASTX_BIT = 3;
  localparam int OSCRST_NFLAG = 4;
  // Clear bits sit in the upper half of the status word
  localparam int OSCRST_CLR_SHIFT = 16;
  // Peripheral reset register layout, then the flag, mask and enable reset values
  localparam logic [31:0] OSCRST_PRST_RESET = 32'h0000_0000;
  localparam logic [31:0] OSCRST_PRST_WMASK = 32'h0007_5a01;
  localparam int OSCRST_TIMER_C_BIT = 18;
  localparam logic [3:0] OSCRST_FLAG_RESET = 4'h0;
  localparam logic [3:0] OSCRST_MASK_RESET = 4'hf;
  localparam logic [3:0] OSCRST_IEN_RESET = 4'h0;

  // Oscillator ready levels
  typedef struct packed {
    logic fast_crystal_osc;
    logic internal_rc_8m_osc;
    logic slow_crystal_osc;
    logic internal_rc_40k_osc;
  } oscrst_ready_t;

  // APB request and response
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } oscrst_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } oscrst_apb_rsp_t;
endpackage : oscrst_pkg

// [hdl/oscrst_sync.sv]
`timescale 1ns/10ps
// Two-stage synchroniser for a vector of asynchronous levels
module oscrst_sync #(
  parameter int WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } oscrst_sync_state_t;

  oscrst_sync_state_t state_reg;
  oscrst_sync_state_t state_next;

  // Shift through two stages
  always_comb begin
    state_next = state_reg;
    if (en) begin
      state_next.meta = d;
      state_next.sync = state_reg.meta;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.sync;
endmodule : oscrst_sync

// [hdl/oscrst_top.sv]
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module oscrst_top
  import oscrst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] osc_ready,
  output logic [31:0] periph_reset,
  output logic irq
);
  // All block state
  typedef struct packed {
    // Status flags with their interrupt mask and enable
    logic [3:0] flag;
    logic [3:0] mask;
    logic [3:0] irq_enable;
    // Peripheral reset register
    logic [31:0] prst;
    // Last synchronised stable levels, for edge detection
    logic [3:0] ready_d;
    // Registered bus answer
    oscrst_apb_rsp_t rsp;
    // Registered interrupt request
    logic irq;
  } oscrst_state_t;

  // Registered state and its next value
  oscrst_state_t state_reg;
  oscrst_state_t state_next;
  // Bus request and synchronised oscillator levels
  oscrst_apb_req_t req;
  oscrst_ready_t ready_sync;
  logic [3:0] ready_vec;

  // Bus request bundled for the decode below
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Oscillator stable levels come from other clock domains
  // The synchroniser advances only while the clock enable is high
  oscrst_sync #(
    .WIDTH(OSCRST_NFLAG)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .d(osc_ready),
    .q(ready_vec)
  );

  // Synchronised levels seen per oscillator
  assign ready_sync = oscrst_ready_t'(ready_vec);

  // Readback word for an address, or error flag for unmapped ones
  function automatic logic [32:0] rd_word(
    input logic [11:0] a,
    input oscrst_state_t s,
    input oscrst_ready_t live
  );
    logic [32:0] r;
    r = 33'h0_0000_0000;
    unique case (a)
      OSCRST_STAT_OFF: r[3:0] = s.flag;
      OSCRST_PRST_OFF: r[31:0] = s.prst;
      OSCRST_MASK_OFF: r[3:0] = s.mask;
      OSCRST_IEN_OFF: r[3:0] = s.irq_enable;
      OSCRST_LIVE_OFF: r[3:0] = live;
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction : rd_word

  // An access is taken while pready is low; a held access is ignored only in the cycle that shows its answer
  function automatic logic access_taken(
    input oscrst_apb_req_t q,
    input logic answered
  );
    return q.psel & q.penable & ~answered;
  endfunction : access_taken

  // Answer for a taken access; writes and refused accesses return zero data
  function automatic oscrst_apb_rsp_t answer(input logic wr, input logic [32:0] w);
    oscrst_apb_rsp_t a;
    a.pready = 1'b1;
    a.pslverr = w[32];
    a.prdata = wr ? 32'h0000_0000 : w[31:0];
    return a;
  endfunction : answer

  // New stable indications since the last enabled cycle
  function automatic logic [3:0] rise_of(input logic [3:0] now_lvl, input logic [3:0] last_lvl);
    return now_lvl & ~last_lvl;
  endfunction : rise_of

  // A new stable level raises its flag only while its interrupt is enabled
  function automatic logic flag_set(
    input logic [3:0] rise,
    input logic [3:0] en,
    input int idx
  );
    return rise[idx] & en[idx];
  endfunction : flag_set

  // Clear strobes sit in the upper half of the status word, one per flag
  function automatic logic [3:0] clear_bits(input logic [31:0] wdata);
    return wdata[OSCRST_CLR_SHIFT +: OSCRST_NFLAG];
  endfunction : clear_bits

  // Next flag word; a set in the same cycle as its clear wins, so no event is lost
  function automatic logic [3:0] flag_update(
    input logic [3:0] cur,
    input logic [3:0] clr,
    input logic [3:0] ev
  );
    return (cur & ~clr) | ev;
  endfunction : flag_update

  // Writable reset bits only; the rest read back as zero
  function automatic logic [31:0] prst_write(input logic [31:0] wdata);
    return wdata & OSCRST_PRST_WMASK;
  endfunction : prst_write

  // Interrupt level from the flags that are not masked
  function automatic logic irq_level(input logic [3:0] flag, input logic [3:0] mask);
    return |(flag & mask);
  endfunction : irq_level

  // Next-state logic: APB slave, flags, peripheral reset and interrupt
  always_comb begin
    logic [3:0] rise;
    logic [3:0] set_ev;
    logic [3:0] clr_ev;
    logic take;
    logic wr_acc;
    logic [32:0] rw;
    // Working values start at zero on every pass
    rise = '0;
    set_ev = '0;
    clr_ev = '0;
    take = 1'b0;
    wr_acc = 1'b0;
    rw = '0;
    // Hold everything while the clock enable is low
    state_next = state_reg;
    if (clk_en) begin
      // Last synchronised level, kept to find new stable indications
      state_next.ready_d = ready_vec;
      rise = rise_of(ready_vec, state_reg.ready_d);
      // Flag events on a new stable indication while enabled
      set_ev[OSCRST_RC8_BIT] = flag_set(rise, state_reg.irq_enable, OSCRST_RC8_BIT);
      set_ev[OSCRST_SLOWX_BIT] = flag_set(rise, state_reg.irq_enable, OSCRST_SLOWX_BIT);
      set_ev[OSCRST_RC40_BIT] = flag_set(rise, state_reg.irq_enable, OSCRST_RC40_BIT);
      set_ev[OSCRST_FASTX_BIT] = flag_set(rise, state_reg.irq_enable, OSCRST_FASTX_BIT);
      // One-cycle answer: ready rises after the first access cycle
      state_next.rsp.pready = 1'b0;
      state_next.rsp.pslverr = 1'b0;
      take = access_taken(req, state_reg.rsp.pready);
      if (take) begin
        rw = rd_word(req.paddr, state_reg, ready_sync);
        state_next.rsp = answer(req.pwrite, rw);
        wr_acc = req.pwrite & ~rw[32];
      end
      // Register writes; refused and read-only addresses change nothing
      if (wr_acc) begin
        unique case (req.paddr)
          OSCRST_STAT_OFF: begin
            clr_ev = clear_bits(req.pwdata);
          end
          OSCRST_PRST_OFF: begin
            // Reserved bits stay zero regardless of what software writes
            state_next.prst = prst_write(req.pwdata);
          end
          OSCRST_MASK_OFF: state_next.mask = req.pwdata[3:0];
          OSCRST_IEN_OFF: state_next.irq_enable = req.pwdata[3:0];
          default: state_next.mask = state_reg.mask;
        endcase
      end
      // Set wins over a clear in the same cycle
      state_next.flag = flag_update(state_reg.flag, clr_ev, set_ev);
      // Interrupt follows the new flags on the same edge
      state_next.irq = irq_level(state_next.flag, state_next.mask);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Flags clear, every flag unmasked, every interrupt disabled
      state_reg.flag <= OSCRST_FLAG_RESET;
      state_reg.mask <= OSCRST_MASK_RESET;
      state_reg.irq_enable <= OSCRST_IEN_RESET;
      // No peripheral held in reset
      state_reg.prst <= OSCRST_PRST_RESET;
      // Edge detector starts at the idle level of the synchroniser
      state_reg.ready_d <= 4'h0;
      state_reg.rsp <= '0;
      state_reg.irq <= 1'b0;
    end else begin
      // The clock enable acts in the next-state logic
      state_reg <= state_next;
    end
  end

  // Bus answer straight from flip-flops
  assign prdata = state_reg.rsp.prdata;
  assign pready = state_reg.rsp.pready;
  assign pslverr = state_reg.rsp.pslverr;
  // Peripheral hold levels and interrupt request, also registered
  assign periph_reset = state_reg.prst;
  assign irq = state_reg.irq;
endmodule : oscrst_top

// [dv/oscrst_top_sva.sv]
`timescale 1ns/10ps
module oscrst_top_sva
  import oscrst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] osc_ready,
  input wire logic [31:0] periph_reset,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access taken by the slave, and a write to the reset register
  sequence s_take;
    psel && penable && !pready && clk_en;
  endsequence
  sequence s_pwr;
    s_take ##0 (pwrite && paddr == OSCRST_PRST_OFF);
  endsequence
  // Bus answer timing and error data
  a_answer_next: assert property (s_take |=> pready) else $error("late pready");
  a_pready_once: assert property (pready && clk_en |=> !pready) else $error("long pready");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("err data");
  // Peripheral reset register follows software writes only
  a_prst_write: assert property (s_pwr |=>
    periph_reset == ($past(pwdata) & OSCRST_PRST_WMASK)) else $error("prst write");
  a_prst_hold: assert property ($changed(periph_reset) |->
    $past(psel && penable && pwrite && paddr == OSCRST_PRST_OFF)) else $error("prst moved");
  a_prst_resv: assert property ((periph_reset & ~OSCRST_PRST_WMASK) == 32'h0)
    else $error("resv bits");
  // Interrupt drops only after a write; frozen state holds
  a_irq_fall: assert property ($fell(irq) |-> $past(psel && pwrite)) else $error("irq drop");
  a_freeze_hold: assert property (!clk_en |=> $stable(periph_reset) && $stable(irq))
    else $error("not frozen");
endmodule : oscrst_top_sva

// [dv/oscrst_top_bench.sv]
`timescale 1ns/10ps
module oscrst_top_bench
  import oscrst_pkg::*;
;
  typedef struct packed {logic [3:0] osc; logic w; logic [11:0] a; logic [31:0] d;
    logic [31:0] rd; logic iq;} oscrst_row_t;
  localparam logic [11:0] P = OSCRST_PRST_OFF;
  localparam logic [11:0] S = OSCRST_STAT_OFF;
  localparam logic [11:0] M = OSCRST_MASK_OFF;
  localparam logic [11:0] N = OSCRST_IEN_OFF;
  localparam logic [11:0] L = OSCRST_LIVE_OFF;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, periph_reset, rd;
  logic [3:0] osc_ready = 4'h0;
  int errors = 0, tests_run = 0;
  // Ready levels, bus op, expected read data and interrupt level
  oscrst_row_t rows [15] = '{
    '{4'h0, 1'b1, P, 32'h0007ffff, 32'h0, 1'b0}, '{4'h0, 1'b0, P, 32'h0, 32'h75a01, 1'b0},
    '{4'h0, 1'b0, M, 32'h0, 32'hf, 1'b0}, '{4'h0, 1'b0, N, 32'h0, 32'h0, 1'b0},
    '{4'h0, 1'b0, 12'h004, 32'h0, 32'h0, 1'b0}, '{4'h0, 1'b1, N, 32'h5, 32'h0, 1'b0},
    '{4'hf, 1'b0, S, 32'h0, 32'h5, 1'b1}, '{4'hf, 1'b1, M, 32'h0, 32'h0, 1'b0},
    '{4'hf, 1'b1, M, 32'hf, 32'h0, 1'b1}, '{4'hf, 1'b1, S, 32'h50000, 32'h0, 1'b0},
    '{4'hf, 1'b1, N, 32'ha, 32'h0, 1'b0}, '{4'h0, 1'b0, S, 32'h0, 32'h0, 1'b0},
    '{4'hf, 1'b0, S, 32'h0, 32'ha, 1'b1}, '{4'hf, 1'b0, L, 32'h0, 32'hf, 1'b1},
    '{4'hf, 1'b1, S, 32'h20000, 32'h0, 1'b1}};
  // Free running bus clock
  always #2 pclk = ~pclk;
  oscrst_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_ready(osc_ready), .periph_reset(periph_reset),
    .irq(irq));
  task automatic summarize;
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Table pass, then freeze and a second reset
  initial begin
    wt(16);
    presetn <= 1'b1;
    check("prst", periph_reset, 32'h0);
    foreach (rows[k]) begin
      osc_ready <= rows[k].osc;
      wt(8);
      apb(rows[k].w, rows[k].a, rows[k].d);
      check("rd", rd, rows[k].rd);
      check("err", 32'(er), 32'(rows[k].a == 12'h004));
      wt(4);
      check("irq", 32'(irq), 32'(rows[k].iq));
    end
    apb(1'b1, S, 32'h80000);
    wt(4);
    check("irq", 32'(irq), 32'h0);
    check("timer", 32'(periph_reset[OSCRST_TIMER_C_BIT]), 32'h1);
    osc_ready <= 4'h0;
    wt(8);
    clk_en <= 1'b0;
    osc_ready <= 4'hf;
    wt(8);
    check("irq", 32'(irq), 32'h0);
    clk_en <= 1'b1;
    wt(8);
    check("irq", 32'(irq), 32'h1);
    presetn <= 1'b0;
    wt(2);
    check("prst", periph_reset, 32'h0);
    check("irq", 32'(irq), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, P, 32'h0);
    check("rd", rd, 32'h0);
    summarize();
  end
endmodule : oscrst_top_bench
bind oscrst_top oscrst_top_sva i_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_ready(osc_ready),
  .periph_reset(periph_reset), .irq(irq));
